// [drive_control_word_decoder.sv]
// drive_control_word_decoder: command word register and power-stage state machine
// assumes process data writes and status inputs synchronous to clock
`timescale 1ns/10ps
module drive_control_word_decoder (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // command word access
   input wire logic cmdWrite,
   input wire logic [15:0] cmdWriteData,
   output logic [15:0] cmdReadData,
   // drive status inputs
   input wire logic voltageReady,
   input wire logic faultDetected,
   input wire logic faultActive,
   input wire logic faultReactionDone,
   input wire logic actionDone,
   input wire logic cancelDone,
   input wire logic quickStopRestartable,
   input wire logic resumePossible,
   // drive controls
   output drive_cmd_pkg::drive_state_e driveState,
   output logic powerStageOn,
   output logic operationEnabled,
   output logic haltRamp,
   output logic motionResume,
   output logic faultClear,
   output logic cancelProgram,
   output logic updateDemand,
   output logic loadActualDemand,
   output logic zeroDemandPos,
   output logic zeroActualPos,
   output logic [3:0] modeBits,
   output logic [4:0] mfrBits
);
   typedef struct packed {
      logic [15:0] word;
      logic prevReset;
      logic prevHalt;
      logic pending;
      drive_cmd_pkg::drive_state_e target;
      drive_cmd_pkg::drive_state_e state;
      logic faultClear;
      logic haltRamp;
      logic motionResume;
      logic updateDemand;
      logic loadActual;
      logic zeroDemand;
      logic zeroActual;
      logic powerOn;
      logic opEnabled;
   } regs_s;

   regs_s r;
   regs_s next_r;
   drive_cmd_pkg::drive_cmd_e cmd;

   command_decode decoder (
      .word(r.word),
      .cmd(cmd)
   );

   always_comb begin
      next_r = r;
      next_r.faultClear = 1'b0;
      next_r.motionResume = 1'b0;
      next_r.updateDemand = 1'b0;
      next_r.zeroDemand = 1'b0;
      next_r.zeroActual = 1'b0;
      if (cmdWrite) begin
         next_r.word = cmdWriteData & drive_cmd_pkg::CMD_WRITE_MASK;
         next_r.updateDemand = 1'b1;
         next_r.loadActual = cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL];
         if (cmdWriteData[drive_cmd_pkg::BIT_ZERO_POS]) begin
            next_r.zeroDemand = cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL];
            next_r.zeroActual = !cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL];
         end
      end else if (cancelDone) begin
         next_r.word[drive_cmd_pkg::BIT_CANCEL] = 1'b0;
      end
      next_r.prevReset = r.word[drive_cmd_pkg::BIT_FAULT_RESET];
      next_r.prevHalt = r.word[drive_cmd_pkg::BIT_HALT];
      next_r.haltRamp = r.word[drive_cmd_pkg::BIT_HALT];
      if (r.prevHalt && !r.word[drive_cmd_pkg::BIT_HALT] && resumePossible) begin
         next_r.motionResume = 1'b1;
      end
      if (faultDetected && r.state != drive_cmd_pkg::FAULT
          && r.state != drive_cmd_pkg::FAULT_REACTION) begin
         next_r.state = drive_cmd_pkg::FAULT_REACTION;
         next_r.pending = 1'b0;
      end else if (r.pending) begin
         if (actionDone) begin
            next_r.state = r.target;
            next_r.pending = 1'b0;
         end
      end else begin
         case (r.state)
            drive_cmd_pkg::NOT_READY: begin
               if (voltageReady) next_r.state = drive_cmd_pkg::SWITCH_ON_DISABLED;
            end
            drive_cmd_pkg::SWITCH_ON_DISABLED: begin
               if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                  next_r.state = drive_cmd_pkg::READY_TO_SWITCH_ON;
               end
            end
            drive_cmd_pkg::READY_TO_SWITCH_ON: begin
               if (cmd == drive_cmd_pkg::CMD_SWITCH_ON
                   || cmd == drive_cmd_pkg::CMD_SWITCH_ON_ENABLE) begin
                  next_r.state = drive_cmd_pkg::SWITCHED_ON;
               end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLTAGE
                            || cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                  next_r.state = drive_cmd_pkg::SWITCH_ON_DISABLED;
               end
            end
            drive_cmd_pkg::SWITCHED_ON: begin
               if (cmd == drive_cmd_pkg::CMD_SWITCH_ON_ENABLE) begin
                  next_r.state = drive_cmd_pkg::OPERATION_ENABLED;
               end else if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                  next_r.state = drive_cmd_pkg::READY_TO_SWITCH_ON;
               end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLTAGE
                            || cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                  next_r.state = drive_cmd_pkg::SWITCH_ON_DISABLED;
               end
            end
            drive_cmd_pkg::OPERATION_ENABLED: begin
               next_r.pending = 1'b1;
               if (cmd == drive_cmd_pkg::CMD_SWITCH_ON) begin
                  next_r.target = drive_cmd_pkg::SWITCHED_ON;
               end else if (cmd == drive_cmd_pkg::CMD_SHUTDOWN) begin
                  next_r.target = drive_cmd_pkg::READY_TO_SWITCH_ON;
               end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLTAGE) begin
                  next_r.target = drive_cmd_pkg::SWITCH_ON_DISABLED;
               end else if (cmd == drive_cmd_pkg::CMD_QUICK_STOP) begin
                  next_r.state = drive_cmd_pkg::QUICK_STOP_ACTIVE;
                  next_r.pending = 1'b0;
               end else begin
                  next_r.pending = 1'b0;
               end
            end
            drive_cmd_pkg::QUICK_STOP_ACTIVE: begin
               if (cmd == drive_cmd_pkg::CMD_SWITCH_ON_ENABLE && quickStopRestartable) begin
                  next_r.state = drive_cmd_pkg::OPERATION_ENABLED;
               end else if (cmd == drive_cmd_pkg::CMD_DISABLE_VOLTAGE || actionDone) begin
                  next_r.state = drive_cmd_pkg::SWITCH_ON_DISABLED;
               end
            end
            drive_cmd_pkg::FAULT_REACTION: begin
               if (faultReactionDone) next_r.state = drive_cmd_pkg::FAULT;
            end
            drive_cmd_pkg::FAULT: begin
               if (r.word[drive_cmd_pkg::BIT_FAULT_RESET] && !r.prevReset) begin
                  next_r.faultClear = 1'b1;
                  if (!faultActive) next_r.state = drive_cmd_pkg::SWITCH_ON_DISABLED;
               end
            end
            default: next_r.state = drive_cmd_pkg::NOT_READY;
         endcase
      end
      next_r.powerOn = next_r.state == drive_cmd_pkg::OPERATION_ENABLED
                       || next_r.state == drive_cmd_pkg::QUICK_STOP_ACTIVE;
      next_r.opEnabled = next_r.state == drive_cmd_pkg::OPERATION_ENABLED;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flops
   assign cmdReadData = r.word;
   assign driveState = r.state;
   assign powerStageOn = r.powerOn;
   assign operationEnabled = r.opEnabled;
   assign haltRamp = r.haltRamp;
   assign motionResume = r.motionResume;
   assign faultClear = r.faultClear;
   assign cancelProgram = r.word[drive_cmd_pkg::BIT_CANCEL];
   assign updateDemand = r.updateDemand;
   assign loadActualDemand = r.loadActual;
   assign zeroDemandPos = r.zeroDemand;
   assign zeroActualPos = r.zeroActual;
   assign modeBits = {r.word[9], r.word[6:4]};
   assign mfrBits = r.word[15:11];

   a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
      !cmdReadData[drive_cmd_pkg::BIT_RESERVED]) else $error("reserved bit set");
   a_reset_edge_only: assert property (@(posedge clock) disable iff (reset)
      faultClear |-> $past(r.word[drive_cmd_pkg::BIT_FAULT_RESET]) && !$past(r.prevReset))
      else $error("bad clear");
   a_no_repeat_clear: assert property (@(posedge clock) disable iff (reset)
      faultClear |=> !faultClear) else $error("repeated clear");
   a_fault_exit: assert property (@(posedge clock) disable iff (reset)
      $past(r.state) == drive_cmd_pkg::FAULT && r.state != drive_cmd_pkg::FAULT
      |-> !$past(faultActive)) else $error("left fault early");
   a_zero_pos: assert property (@(posedge clock) disable iff (reset)
      cmdWrite && cmdWriteData[drive_cmd_pkg::BIT_ZERO_POS]
      |=> zeroDemandPos == $past(cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL])
      && zeroActualPos != $past(cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL]))
      else $error("zero pos wrong");
   a_update_sel: assert property (@(posedge clock) disable iff (reset)
      cmdWrite |=> updateDemand
      && loadActualDemand == $past(cmdWriteData[drive_cmd_pkg::BIT_UPDATE_ACTUAL]))
      else $error("update wrong");
   a_cancel_clear: assert property (@(posedge clock) disable iff (reset)
      cancelDone && !cmdWrite |=> !cancelProgram) else $error("cancel held");
   a_halt_follow: assert property (@(posedge clock) disable iff (reset)
      ##1 haltRamp == $past(r.word[drive_cmd_pkg::BIT_HALT])) else $error("halt lag");
   a_wait_action: assert property (@(posedge clock) disable iff (reset)
      r.pending && !actionDone && !faultDetected |=> $stable(r.state))
      else $error("left early");
   c_enable: cover property (@(posedge clock) operationEnabled);
   c_fault_clear: cover property (@(posedge clock) faultClear);
   c_quick_stop: cover property (@(posedge clock) r.state == drive_cmd_pkg::QUICK_STOP_ACTIVE);
endmodule // drive_control_word_decoder

// [drive_cmd_pkg.sv]
// drive_cmd_pkg: command word layout, drive states and command codes
// assumes a single clock domain at 100 MHz
package drive_cmd_pkg;
   localparam logic [15:0] CMD_WORD_INDEX = 16'h6040;
   localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
   localparam logic [15:0] CMD_WRITE_MASK = 16'hfbff;
   localparam int BIT_SWITCH_ON = 0;
   localparam int BIT_ENABLE_VOLTAGE = 1;
   localparam int BIT_QUICK_STOP = 2;
   localparam int BIT_ENABLE_OP = 3;
   localparam int BIT_FAULT_RESET = 7;
   localparam int BIT_HALT = 8;
   localparam int BIT_RESERVED = 10;
   localparam int BIT_ZERO_POS = 12;
   localparam int BIT_CANCEL = 13;
   localparam int BIT_UPDATE_ACTUAL = 14;
   localparam int BIT_REGISTRATION = 15;
   localparam logic [3:0] MODE_BITS_MASK = 4'hf;
   localparam logic [4:0] MFR_BITS_MASK = 5'h1f;

   typedef enum logic [2:0] {
      NOT_READY, SWITCH_ON_DISABLED, READY_TO_SWITCH_ON, SWITCHED_ON,
      OPERATION_ENABLED, QUICK_STOP_ACTIVE, FAULT_REACTION, FAULT
   } drive_state_e;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_SWITCH_ON_ENABLE,
      CMD_DISABLE_VOLTAGE, CMD_QUICK_STOP
   } drive_cmd_e;
endpackage

// [command_decode.sv]
// command_decode: classifies the low command bits into a power-stage command
// assumes a combinational leaf used by drive_control_word_decoder
`timescale 1ns/10ps
module command_decode (
   // command word
   input wire logic [15:0] word,
   // decoded command
   output drive_cmd_pkg::drive_cmd_e cmd
);
   always_comb begin
      cmd = drive_cmd_pkg::CMD_NONE;
      if (word[drive_cmd_pkg::BIT_FAULT_RESET]) begin
         cmd = drive_cmd_pkg::CMD_NONE;
      end else if (!word[drive_cmd_pkg::BIT_ENABLE_VOLTAGE]) begin
         cmd = drive_cmd_pkg::CMD_DISABLE_VOLTAGE;
      end else if (!word[drive_cmd_pkg::BIT_QUICK_STOP]) begin
         cmd = drive_cmd_pkg::CMD_QUICK_STOP;
      end else if (!word[drive_cmd_pkg::BIT_SWITCH_ON]) begin
         cmd = drive_cmd_pkg::CMD_SHUTDOWN;
      end else if (word[drive_cmd_pkg::BIT_ENABLE_OP]) begin
         cmd = drive_cmd_pkg::CMD_SWITCH_ON_ENABLE;
      end else begin
         cmd = drive_cmd_pkg::CMD_SWITCH_ON;
      end
   end
endmodule // command_decode

// [fieldbus_master_model.sv]
// fieldbus_master_model: master side writing process data into the command word
// assumes write requests from the bench, synchronous to clock
`timescale 1ns/10ps
module fieldbus_master_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // requests from the bench
   input wire logic reqValid,
   input wire logic [15:0] reqData,
   input wire logic breakReserved,
   // process data write
   output logic cmdWrite,
   output logic [15:0] cmdWriteData
);
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cmdWrite <= 1'b0;
         cmdWriteData <= 16'h0000;
      end else begin
         cmdWrite <= reqValid;
         // reserved bit zero on writes unless a test breaks it; data inverted every idle cycle
         if (reqValid) begin
            cmdWriteData <= breakReserved ? reqData : (reqData & 16'hfbff);
         end else begin
            cmdWriteData <= ~cmdWriteData;
         end
      end
   end
endmodule // fieldbus_master_model

// [drive_control_word_decoder_tb.sv]
// drive_control_word_decoder_tb: scenarios for the command word decoder
// assumes the master model in front and status inputs driven here
`timescale 1ns/10ps
module drive_control_word_decoder_tb;
   logic clock, reset, reqValid, breakReserved, cmdWrite;
   logic [15:0] reqData, cmdWriteData, cmdReadData;
   logic voltageReady, faultDetected, faultActive, faultReactionDone, actionDone;
   logic cancelDone, quickStopRestartable, resumePossible;
   drive_cmd_pkg::drive_state_e driveState;
   logic powerStageOn, operationEnabled, haltRamp, motionResume, faultClear, cancelProgram;
   logic updateDemand, loadActualDemand, zeroDemandPos, zeroActualPos;
   logic [3:0] modeBits;
   logic [4:0] mfrBits;
   int errorCnt = 0, testsRun = 0, resumeCnt = 0, clearCnt = 0;
   fieldbus_master_model master (.clock, .reset, .reqValid, .reqData, .breakReserved,
      .cmdWrite, .cmdWriteData);
   drive_control_word_decoder dut (.clock, .reset, .cmdWrite, .cmdWriteData, .cmdReadData,
      .voltageReady, .faultDetected, .faultActive, .faultReactionDone, .actionDone,
      .cancelDone, .quickStopRestartable, .resumePossible, .driveState, .powerStageOn,
      .operationEnabled, .haltRamp, .motionResume, .faultClear, .cancelProgram,
      .updateDemand, .loadActualDemand, .zeroDemandPos, .zeroActualPos, .modeBits, .mfrBits);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // pulse counters
   always @(posedge clock) begin
      if (motionResume === 1'b1) resumeCnt++;
      if (faultClear === 1'b1) clearCnt++;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [15:0] d, input logic brk = 1'b0);
      @(posedge clock);
      reqValid <= 1'b1;
      reqData <= d;
      breakReserved <= brk;
      @(posedge clock);
      reqValid <= 1'b0;
      @(posedge clock);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic tallyAndFinish;
      $display("checks %0d, mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic testWordBits;
      chk(cmdReadData, 16'h0000);
      chk(driveState, drive_cmd_pkg::NOT_READY);
      put(16'hffff, 1'b1);
      chk(cmdReadData, 16'hfbff);
      chk({zeroDemandPos, zeroActualPos, loadActualDemand, cancelProgram, updateDemand}, 5'h17);
      chk({modeBits, mfrBits}, 9'h1ff);
      tick(1);
      chk({haltRamp, updateDemand, zeroDemandPos}, 3'h4);
      @(posedge clock);
      cancelDone <= 1'b1;
      @(posedge clock);
      cancelDone <= 1'b0;
      tick(1);
      chk({cancelProgram, cmdReadData[13]}, 2'h0);
      resumePossible <= 1'b1;
      resumeCnt = 0;
      put(16'h1220);
      chk({zeroDemandPos, zeroActualPos, loadActualDemand}, 3'h2);
      chk(modeBits, 4'ha);
      tick(3);
      chk({haltRamp, resumeCnt[3:0]}, 5'h01);
      $display("test word bits done");
   endtask
   task automatic testPower;
      @(posedge clock);
      voltageReady <= 1'b1;
      quickStopRestartable <= 1'b1;
      tick(2);
      chk(driveState, drive_cmd_pkg::SWITCH_ON_DISABLED);
      put(16'h0007);
      tick(1);
      chk(driveState, drive_cmd_pkg::SWITCH_ON_DISABLED);
      put(16'h0086);
      tick(1);
      chk(driveState, drive_cmd_pkg::SWITCH_ON_DISABLED);
      put(16'h0006);
      tick(1);
      chk(driveState, drive_cmd_pkg::READY_TO_SWITCH_ON);
      put(16'h0007);
      tick(1);
      chk(driveState, drive_cmd_pkg::SWITCHED_ON);
      put(16'h000f);
      tick(1);
      chk({driveState, powerStageOn, operationEnabled}, {drive_cmd_pkg::OPERATION_ENABLED, 2'h3});
      put(16'h0007);
      tick(2);
      chk(driveState, drive_cmd_pkg::OPERATION_ENABLED);
      @(posedge clock);
      actionDone <= 1'b1;
      @(posedge clock);
      actionDone <= 1'b0;
      tick(1);
      chk(driveState, drive_cmd_pkg::SWITCHED_ON);
      put(16'h000f);
      put(16'h000b);
      tick(1);
      chk({driveState, powerStageOn, operationEnabled}, {drive_cmd_pkg::QUICK_STOP_ACTIVE, 2'h2});
      put(16'h000f);
      tick(1);
      chk(driveState, drive_cmd_pkg::OPERATION_ENABLED);
      put(16'h0000);
      tick(1);
      chk(driveState, drive_cmd_pkg::OPERATION_ENABLED);
      @(posedge clock);
      actionDone <= 1'b1;
      @(posedge clock);
      actionDone <= 1'b0;
      tick(1);
      chk(driveState, drive_cmd_pkg::SWITCH_ON_DISABLED);
      $display("test power sequence done");
   endtask
   task automatic testFault;
      @(posedge clock);
      faultDetected <= 1'b1;
      faultActive <= 1'b1;
      tick(2);
      chk(driveState, drive_cmd_pkg::FAULT_REACTION);
      @(posedge clock);
      faultReactionDone <= 1'b1;
      faultDetected <= 1'b0;
      tick(2);
      chk(driveState, drive_cmd_pkg::FAULT);
      clearCnt = 0;
      put(16'h0080);
      tick(2);
      chk({driveState, clearCnt[3:0]}, {drive_cmd_pkg::FAULT, 4'h1});
      clearCnt = 0;
      put(16'h0080);
      tick(2);
      chk(clearCnt[3:0], 4'h0);
      put(16'h0000);
      faultActive <= 1'b0;
      clearCnt = 0;
      put(16'h0080);
      tick(2);
      chk({driveState, clearCnt[3:0]}, {drive_cmd_pkg::SWITCH_ON_DISABLED, 4'h1});
      put(16'h0000);
      $display("test fault reset done");
   endtask
   initial begin
      reset = 1'b1;
      {reqValid, breakReserved, voltageReady, faultDetected, faultActive} = 5'h00;
      {faultReactionDone, actionDone, cancelDone, quickStopRestartable, resumePossible} = 5'h00;
      reqData = 16'h0000;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      tick(1);
      testWordBits();
      testPower();
      testFault();
      tallyAndFinish();
   end
   initial begin
      repeat (3000) @(posedge clock);
      errorCnt++;
      tallyAndFinish();
   end
endmodule // drive_control_word_decoder_tb
